// ==== logic/tiny_core.sv ====
// Tiny 8-bit core: fetch/decode/execute, low-power and halted states, pointer cell.
// Assumes an asynchronous-read byte memory on mem_* (data valid in the cycle the
// address is shown) and an Avalon-MM master on the register port.

`timescale 1ns/100ps

module tiny_core (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [13:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        irq_pin,
	output logic             cpu_clk_en,
	output logic             halted,
	output logic             low_power,
	output logic             illegal_opcode
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Window access becomes the direct-page cell named by the pointer
	function automatic logic [13:0] redirect(input logic [13:0] a, input logic [7:0] x);
		// RQ8 window redirect
		return (a == tiny_core_pkg::WIN_ADDR) ? {6'h00, x} : a;
	endfunction : redirect

	// Returns {carry, zero, result}; AND and load keep carry
	function automatic logic [9:0] alu(input tiny_core_pkg::alu_op_t op, input logic [7:0] a,
	                                   input logic [7:0] m, input logic c);
		logic [8:0] s;
		s = {c, a};
		unique case (op)
			tiny_core_pkg::ALU_ADC: s = {1'b0, a} + {1'b0, m} + {8'h00, c};
			tiny_core_pkg::ALU_ADD: s = {1'b0, a} + {1'b0, m};
			tiny_core_pkg::ALU_AND: s = {c, a & m};
			tiny_core_pkg::ALU_LDA: s = {c, m};
			tiny_core_pkg::ALU_NONE: s = {c, a};
		endcase
		return {s[8], s[7:0] == 8'h00, s[7:0]};
	endfunction : alu

	// Branch condition from the low opcode bits kept at fetch: carry clear, carry set, zero
	function automatic logic br_taken(input logic [1:0] sel, input logic c, input logic z);
		return (sel == 2'b00) ? ~c : (sel == 2'b01) ? c : z;
	endfunction : br_taken

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tiny_core_pkg::core_state_t state_q, state_d, ret_q, ret_d;
	tiny_core_pkg::alu_op_t     op_q, op_d;
	tiny_core_pkg::opnd_kind_t  kind_q, kind_d;
	logic [1:0]  br_sel_q, br_sel_d;
	logic        halted_q, low_power_q;
	logic [5:0]  program_counter_high_q, program_counter_high_d;
	logic [7:0]  program_counter_low_q, program_counter_low_d;
	logic [5:0]  shadow_counter_high_q, shadow_counter_high_d;
	logic [7:0]  shadow_counter_low_q, shadow_counter_low_d;
	logic [7:0]  acc_q, acc_d;
	logic        zf_q, zf_d;
	logic        cf_q, cf_d;
	logic [5:0]  ext_hi_q, ext_hi_d;
	logic        stop_q, stop_d;
	logic [7:0]  pointer_cell_q;
	logic        halt_req_q;
	logic        ill_sticky_q;
	logic [13:0] mem_addr_q, mem_addr_d;
	logic        mem_rd_q, mem_rd_d;
	logic        mem_wr_q, mem_wr_d;
	logic [7:0]  mem_wdata_q, mem_wdata_d;
	logic        clk_en_q, clk_en_d;
	logic        ill_q, ill_d;
	logic [31:0] rdata_q;
	logic        wait_q;
	logic        irq_s1_q, irq_s2_q, irq_s3_q;

	// ----------------------------------------------------------------
	// Decode of the fetched opcode and shared arithmetic
	// ----------------------------------------------------------------
	// RQ5 split counter
	wire [13:0] pc      = {program_counter_high_q, program_counter_low_q};
	// RQ6 split shadow
	wire [13:0] shadow  = {shadow_counter_high_q, shadow_counter_low_q};
	wire [13:0] pc_p1   = pc + tiny_core_pkg::PC_STEP1;
	wire [13:0] pc_p2   = pc + tiny_core_pkg::PC_STEP2;
	wire [7:0]  opc     = mem_rdata;
	wire        is_imm  = (opc == tiny_core_pkg::OP_ADC_IMM) || (opc == tiny_core_pkg::OP_ADD_IMM) ||
	                      (opc == tiny_core_pkg::OP_AND_IMM);
	wire        is_dir  = (opc == tiny_core_pkg::OP_ADC_DIR) || (opc == tiny_core_pkg::OP_ADD_DIR) ||
	                      (opc == tiny_core_pkg::OP_AND_DIR);
	wire        is_tny  = (opc[7:4] == tiny_core_pkg::OP_ADD_TNY);
	wire        is_srt  = (opc[7:5] == tiny_core_pkg::OP_LDA_SRT);
	wire        is_br   = (opc == tiny_core_pkg::OP_BCC) || (opc == tiny_core_pkg::OP_BCS) ||
	                      (opc == tiny_core_pkg::OP_BEQ);
	wire        is_lp   = (opc == tiny_core_pkg::OP_WAIT) || (opc == tiny_core_pkg::OP_STOP);
	// Operation class from the low nibble shared by immediate and direct forms
	wire tiny_core_pkg::alu_op_t dec_op =
		(opc[3:0] == 4'h9) ? tiny_core_pkg::ALU_ADC :
		(opc[3:0] == 4'hB) ? tiny_core_pkg::ALU_ADD : tiny_core_pkg::ALU_AND;
	// RQ12 four-bit page
	wire [13:0] tny_ea  = redirect({10'h000, opc[3:0]}, pointer_cell_q);
	// RQ13 five-bit page
	wire [13:0] srt_ea  = redirect({9'h000, opc[4:0]}, pointer_cell_q);
	// RQ10 direct page
	wire [13:0] dir_ea  = redirect({6'h00, mem_rdata}, pointer_cell_q);
	// RQ14 signed offset
	wire [13:0] br_tgt  = pc_p2 + {{6{mem_rdata[7]}}, mem_rdata};
	// RQ7 pointer cell is served here, memory data is ignored for it
	wire [7:0]  data_in = (mem_addr_q == tiny_core_pkg::PTR_ADDR) ? pointer_cell_q : mem_rdata;
	wire [9:0]  alu_imm = alu(op_q, acc_q, mem_rdata, cf_q);
	wire [9:0]  alu_mem = alu(op_q, acc_q, data_in, cf_q);
	// RQ3 wake on agreed level
	wire        wake    = irq_s2_q & irq_s3_q;
	// Opcode is gone from the bus in the operand phase, so the condition uses the kept bits
	wire        br_go   = br_taken(br_sel_q, cf_q, zf_q);
	// Debug window access keeps the halted indication up while it borrows the memory port
	wire        halted_d = (state_d == tiny_core_pkg::S_HALT) ||
	                       (state_d == tiny_core_pkg::S_XFER && ret_d == tiny_core_pkg::S_HALT);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	wire req      = avs_read | avs_write;
	wire ans      = req & ~wait_q;
	wire hit_win  = (avs_address == tiny_core_pkg::REG_WIN);
	wire core_idl = (state_q == tiny_core_pkg::S_HALT) || (state_q == tiny_core_pkg::S_LOWPWR);
	// Window needs the memory port, so it waits until the core is parked
	wire xfer_go  = req & wait_q & hit_win & core_idl;
	wire xfer_fin = (state_q == tiny_core_pkg::S_XFER);
	wire reg_go   = req & wait_q & ~hit_win;
	wire wr_ctrl  = ans & avs_write & avs_byteenable[0] & (avs_address == tiny_core_pkg::REG_CTRL);
	wire wr_stat  = ans & avs_write & avs_byteenable[0] & (avs_address == tiny_core_pkg::REG_STATUS);
	wire wr_ptr   = ans & avs_write & avs_byteenable[0] & (avs_address == tiny_core_pkg::REG_PTR);
	wire resume   = wr_ctrl & avs_writedata[tiny_core_pkg::CTRL_RESUME_BIT];
	wire [31:0] status_w = {20'h00000, state_q, 2'b00, cf_q, zf_q, stop_q,
	                        low_power, halted, ill_sticky_q};
	wire [31:0] rd_mux =
		(avs_address == tiny_core_pkg::REG_CTRL)   ? {31'h0, halt_req_q} :
		(avs_address == tiny_core_pkg::REG_STATUS) ? status_w :
		(avs_address == tiny_core_pkg::REG_PC)     ? {2'b00, shadow, 2'b00, pc} :
		(avs_address == tiny_core_pkg::REG_ACC)    ? {24'h000000, acc_q} :
		(avs_address == tiny_core_pkg::REG_PTR)    ? {24'h000000, pointer_cell_q} : 32'h00000000;

	// ----------------------------------------------------------------
	// Core sequencer
	// ----------------------------------------------------------------
	// Next-state logic for every instruction phase
	always_comb begin
		state_d  = state_q;
		ret_d    = ret_q;
		op_d     = op_q;
		kind_d   = kind_q;
		br_sel_d = br_sel_q;
		{program_counter_high_d, program_counter_low_d} = pc;
		{shadow_counter_high_d, shadow_counter_low_d}   = shadow;
		acc_d    = acc_q;
		zf_d     = zf_q;
		cf_d     = cf_q;
		ext_hi_d = ext_hi_q;
		stop_d   = stop_q;
		mem_addr_d  = mem_addr_q;
		mem_rd_d    = mem_rd_q;
		mem_wr_d    = 1'b0;
		mem_wdata_d = mem_wdata_q;
		clk_en_d    = clk_en_q;
		ill_d       = 1'b0;
		unique case (state_q)
			tiny_core_pkg::S_FETCH: begin
				if (halt_req_q) begin
					// RQ4 stop fetching
					state_d  = tiny_core_pkg::S_HALT;
					mem_rd_d = 1'b0;
				end else if (is_imm) begin
					// RQ15 one-byte immediate
					op_d       = dec_op;
					mem_addr_d = pc_p1;
					state_d    = tiny_core_pkg::S_IMM;
				end else if (is_dir || is_br || opc == tiny_core_pkg::OP_JMP) begin
					op_d       = is_dir ? dec_op : tiny_core_pkg::ALU_NONE;
					br_sel_d   = opc[1:0];
					kind_d     = is_dir ? tiny_core_pkg::K_DIR :
					             is_br ? tiny_core_pkg::K_BR : tiny_core_pkg::K_JMP;
					mem_addr_d = pc_p1;
					state_d    = tiny_core_pkg::S_OPND;
				end else if (is_tny || is_srt) begin
					// RQ17 tiny-page add
					op_d       = is_tny ? tiny_core_pkg::ALU_ADD : tiny_core_pkg::ALU_LDA;
					mem_addr_d = is_tny ? tny_ea : srt_ea;
					{program_counter_high_d, program_counter_low_d} = pc_p1;
					state_d    = tiny_core_pkg::S_INT;
				end else if (opc == tiny_core_pkg::OP_SHIFT) begin
					// RQ19 same as logical shift
					acc_d      = {acc_q[6:0], 1'b0};
					cf_d       = acc_q[7];
					zf_d       = (acc_q[6:0] == 7'h00);
					mem_addr_d = pc_p1;
					{program_counter_high_d, program_counter_low_d} = pc_p1;
				end else if (is_lp) begin
					// RQ1 enter low power
					stop_d     = (opc == tiny_core_pkg::OP_STOP);
					{shadow_counter_high_d, shadow_counter_low_d}   = pc_p1;
					{program_counter_high_d, program_counter_low_d} = pc_p1;
					mem_addr_d = pc_p1;
					mem_rd_d   = 1'b0;
					// RQ2 gate core clock
					clk_en_d   = 1'b0;
					state_d    = tiny_core_pkg::S_LOWPWR;
				end else if (opc == tiny_core_pkg::OP_BGND) begin
					{program_counter_high_d, program_counter_low_d} = pc_p1;
					mem_addr_d = pc_p1;
					mem_rd_d   = 1'b0;
					state_d    = tiny_core_pkg::S_HALT;
				end else begin
					// RQ23 flag undefined opcode
					ill_d      = 1'b1;
					{program_counter_high_d, program_counter_low_d} = pc_p1;
					mem_addr_d = pc_p1;
				end
			end
			tiny_core_pkg::S_IMM: begin
				// RQ16 two-cycle immediate forms
				{cf_d, zf_d, acc_d} = alu_imm;
				{program_counter_high_d, program_counter_low_d} = pc_p2;
				mem_addr_d = pc_p2;
				state_d    = tiny_core_pkg::S_FETCH;
			end
			tiny_core_pkg::S_OPND: begin
				unique case (kind_q)
					tiny_core_pkg::K_DIR: begin
						mem_addr_d = dir_ea;
						{program_counter_high_d, program_counter_low_d} = pc_p2;
						state_d    = tiny_core_pkg::S_DATA;
					end
					tiny_core_pkg::K_BR: begin
						// Taken or not, the branch costs three cycles
						// RQ14 relative branch
						{program_counter_high_d, program_counter_low_d} = br_go ? br_tgt : pc_p2;
						mem_addr_d = br_go ? br_tgt : pc_p2;
						state_d = tiny_core_pkg::S_INT;
					end
					tiny_core_pkg::K_JMP: begin
						// RQ11 high part, top two bits dropped
						ext_hi_d   = mem_rdata[5:0];
						mem_addr_d = pc_p2;
						state_d    = tiny_core_pkg::S_EXT;
					end
					default: state_d = tiny_core_pkg::S_FETCH;
				endcase
			end
			tiny_core_pkg::S_EXT: begin
				{program_counter_high_d, program_counter_low_d} = {ext_hi_q, mem_rdata};
				mem_addr_d = {ext_hi_q, mem_rdata};
				state_d    = tiny_core_pkg::S_FETCH;
			end
			tiny_core_pkg::S_INT: begin
				state_d = (op_q == tiny_core_pkg::ALU_NONE) ? tiny_core_pkg::S_FETCH : tiny_core_pkg::S_DATA;
			end
			tiny_core_pkg::S_DATA: begin
				// RQ18 carry kept for AND
				{cf_d, zf_d, acc_d} = alu_mem;
				mem_addr_d = pc;
				state_d    = tiny_core_pkg::S_FETCH;
			end
			tiny_core_pkg::S_LOWPWR: begin
				if (xfer_go) begin
					ret_d       = state_q;
					state_d     = tiny_core_pkg::S_XFER;
					mem_addr_d  = {6'h00, pointer_cell_q};
					mem_rd_d    = avs_read;
					mem_wr_d    = avs_write;
					mem_wdata_d = avs_writedata[7:0];
				end else if (wake) begin
					// RQ22 resume after wait/stop
					{program_counter_high_d, program_counter_low_d} = shadow;
					mem_addr_d = shadow;
					mem_rd_d   = 1'b1;
					clk_en_d   = 1'b1;
					stop_d     = 1'b0;
					state_d    = tiny_core_pkg::S_FETCH;
				end
			end
			tiny_core_pkg::S_HALT: begin
				if (xfer_go) begin
					ret_d       = state_q;
					state_d     = tiny_core_pkg::S_XFER;
					mem_addr_d  = {6'h00, pointer_cell_q};
					mem_rd_d    = avs_read;
					mem_wr_d    = avs_write;
					mem_wdata_d = avs_writedata[7:0];
				end else if (resume && !avs_writedata[tiny_core_pkg::CTRL_HALT_BIT]) begin
					mem_rd_d = 1'b1;
					state_d  = tiny_core_pkg::S_FETCH;
				end
			end
			tiny_core_pkg::S_XFER: begin
				mem_addr_d = pc;
				mem_rd_d   = 1'b0;
				state_d    = ret_q;
			end
			default: state_d = tiny_core_pkg::S_FETCH;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// RQ20 reset vector
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= tiny_core_pkg::S_FETCH;
			ret_q      <= tiny_core_pkg::S_HALT;
			op_q       <= tiny_core_pkg::ALU_NONE;
			kind_q     <= tiny_core_pkg::K_DIR;
			br_sel_q   <= 2'b00;
			halted_q   <= 1'b0;
			low_power_q <= 1'b0;
			{program_counter_high_q, program_counter_low_q} <= tiny_core_pkg::RESET_PC;
			{shadow_counter_high_q, shadow_counter_low_q}   <= tiny_core_pkg::RESET_PC;
			mem_addr_q <= tiny_core_pkg::RESET_PC;
			mem_rd_q   <= 1'b1;
			clk_en_q   <= 1'b1;
		end else begin
			state_q    <= state_d;
			ret_q      <= ret_d;
			op_q       <= op_d;
			kind_q     <= kind_d;
			br_sel_q   <= br_sel_d;
			halted_q   <= halted_d;
			low_power_q <= ~clk_en_d;
			{program_counter_high_q, program_counter_low_q} <= {program_counter_high_d, program_counter_low_d};
			{shadow_counter_high_q, shadow_counter_low_q}   <= {shadow_counter_high_d, shadow_counter_low_d};
			mem_addr_q <= mem_addr_d;
			mem_rd_q   <= mem_rd_d;
			clk_en_q   <= clk_en_d;
		end
	end

	// RQ9 two flags only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_q       <= tiny_core_pkg::ACC_RESET;
			zf_q        <= 1'b0;
			cf_q        <= 1'b0;
			ext_hi_q    <= 6'h00;
			stop_q      <= 1'b0;
			mem_wr_q    <= 1'b0;
			mem_wdata_q <= 8'h00;
			ill_q       <= 1'b0;
		end else begin
			acc_q       <= acc_d;
			zf_q        <= zf_d;
			cf_q        <= cf_d;
			ext_hi_q    <= ext_hi_d;
			stop_q      <= stop_d;
			mem_wr_q    <= mem_wr_d;
			mem_wdata_q <= mem_wdata_d;
			ill_q       <= ill_d;
		end
	end

	// RQ21 interrupt only seen by the low-power state; three-stage pin sync
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			irq_s3_q <= 1'b0;
		end else begin
			irq_s1_q <= irq_pin;
			irq_s2_q <= irq_s1_q;
			irq_s3_q <= irq_s2_q;
		end
	end

	// Software-visible registers; a new illegal event beats a same-cycle clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pointer_cell_q <= tiny_core_pkg::PTR_RESET;
			halt_req_q     <= 1'b0;
			ill_sticky_q   <= 1'b0;
		end else begin
			if (wr_ptr)
				pointer_cell_q <= avs_writedata[7:0];
			if (wr_ctrl)
				halt_req_q <= avs_writedata[tiny_core_pkg::CTRL_HALT_BIT];
			if (ill_d)
				ill_sticky_q <= 1'b1;
			else if (wr_stat && avs_writedata[tiny_core_pkg::STAT_ILL_BIT])
				ill_sticky_q <= 1'b0;
		end
	end

	// Bus answer: one wait cycle for plain registers, window after its memory cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			wait_q <= ~(reg_go | xfer_fin);
			if (reg_go)
				rdata_q <= rd_mux;
			else if (xfer_fin)
				rdata_q <= {24'h000000, data_in};
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign mem_addr        = mem_addr_q;
	assign mem_rd          = mem_rd_q;
	assign mem_wr          = mem_wr_q;
	assign mem_wdata       = mem_wdata_q;
	assign cpu_clk_en      = clk_en_q;
	assign illegal_opcode  = ill_q;
	assign low_power       = low_power_q;
	assign halted          = halted_q;

endmodule : tiny_core

// ==== inc/tiny_core_pkg.sv ====
// Constants, opcodes, register map and state encodings for the tiny 8-bit core.
// Assumes one 10 MHz clock, an asynchronous active-low reset and a byte-wide memory port.
//
// Summary of operation
// RQ1 - WAIT instruction enters wait state, STOP instruction enters stop state.
// RQ2 - In either low-power state the core clock is gated and activity suspended.
// RQ3 - Low-power state lasts until an interrupt or a reset wakes the core.
// RQ4 - Halted debug state stops fetching and waits for debug commands.
// RQ5 - Program counter is a six-bit high part plus eight-bit low part.
// RQ6 - Shadow program counter has the same six-plus-eight bit split.
// RQ7 - Pointer cell is an ordinary location at 000F, not a core register; the core holds it in pointer_cell_q and serves reads of 000F from it.
// RQ8 - Access to 000E is redirected to the direct-page address in the pointer.
// RQ9 - Condition flags are exactly a zero flag and a carry/borrow flag.
// RQ10 - Direct operand byte gives low address bits, high byte zero, up to 00FF.
// RQ11 - Extended address is two bytes: 00 plus six high bits, then low byte.
// RQ12 - Four-bit page mode takes opcode low four bits, zero-extended, 0000-000F.
// RQ13 - Five-bit page mode takes opcode low five bits, zero-extended, up to 001F.
// RQ14 - Branch adds signed eight-bit offset to next address, reach -128 to +127.
// RQ15 - Every immediate operand is one byte directly after the opcode.
// RQ16 - Add-with-carry: A9 in 2 cycles, B9 in 3, both flags updated.
// RQ17 - Plain add: AB in 2 cycles; BB, 6x, 6E, 6F in 3, both flags.
// RQ18 - AND: A4 in 2 cycles, B4 in 3, zero flag updated, carry kept.
// RQ19 - Arithmetic left shift behaves exactly like the logical left shift.
// RQ20 - After reset the program counter is 3FFD and fetching starts there.
// RQ21 - Interrupts only wake from low power; while running they are ignored.
// RQ22 - After an interrupt wake, fetch resumes after the wait or stop instruction.
// RQ23 - Undefined opcodes are flagged as an illegal-opcode reset source.

package tiny_core_pkg;

	// ----------------------------------------------------------------
	// Addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [13:0] RESET_PC   = 14'h3FFD;
	localparam logic [13:0] PTR_ADDR   = 14'h000F;
	localparam logic [13:0] WIN_ADDR   = 14'h000E;
	localparam logic [13:0] PC_STEP1   = 14'h0001;
	localparam logic [13:0] PC_STEP2   = 14'h0002;
	localparam logic [7:0]  PTR_RESET  = 8'h00;
	localparam logic [7:0]  ACC_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// Opcodes (wait, stop, jump and short load codes are free choices)
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_ADC_IMM = 8'hA9;
	localparam logic [7:0] OP_ADC_DIR = 8'hB9;
	localparam logic [7:0] OP_ADD_IMM = 8'hAB;
	localparam logic [7:0] OP_ADD_DIR = 8'hBB;
	localparam logic [3:0] OP_ADD_TNY = 4'h6;
	localparam logic [7:0] OP_AND_IMM = 8'hA4;
	localparam logic [7:0] OP_AND_DIR = 8'hB4;
	localparam logic [2:0] OP_LDA_SRT = 3'h6;
	localparam logic [7:0] OP_SHIFT   = 8'h48;
	localparam logic [7:0] OP_BCC     = 8'h34;
	localparam logic [7:0] OP_BCS     = 8'h35;
	localparam logic [7:0] OP_BEQ     = 8'h37;
	localparam logic [7:0] OP_BGND    = 8'hBF;
	localparam logic [7:0] OP_WAIT    = 8'hAF;
	localparam logic [7:0] OP_STOP    = 8'hAE;
	localparam logic [7:0] OP_JMP     = 8'hBC;

	// ----------------------------------------------------------------
	// Avalon register map (byte addresses); window and pointer sit at index*4
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_WIN        = 8'h0E;
	localparam logic [7:0] IDX_PTR        = 8'h0F;
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_PC         = 8'h08;
	localparam logic [7:0] REG_ACC        = 8'h0C;
	localparam logic [7:0] REG_WIN        = 8'(IDX_WIN * 4);
	localparam logic [7:0] REG_PTR        = 8'(IDX_PTR * 4);
	localparam int         CTRL_HALT_BIT  = 0;
	localparam int         CTRL_RESUME_BIT = 1;
	localparam int         STAT_ILL_BIT   = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_FETCH  = 4'b0000,
		S_IMM    = 4'b0001,
		S_OPND   = 4'b0010,
		S_INT    = 4'b0011,
		S_DATA   = 4'b0100,
		S_EXT    = 4'b0101,
		S_LOWPWR = 4'b0110,
		S_HALT   = 4'b0111,
		S_XFER   = 4'b1000
	} core_state_t;

	typedef enum logic [2:0] {
		ALU_NONE = 3'b000,
		ALU_ADC  = 3'b001,
		ALU_ADD  = 3'b010,
		ALU_AND  = 3'b011,
		ALU_LDA  = 3'b100
	} alu_op_t;

	typedef enum logic [1:0] {
		K_DIR = 2'b00,
		K_BR  = 2'b01,
		K_JMP = 2'b10
	} opnd_kind_t;

endpackage : tiny_core_pkg

// ==== dv/core_monitor.sv ====
// Checker for the tiny core, watching only its top-level ports.
// Assumes one clock and the asynchronous active-low reset of the core.
`timescale 1ns/100ps
module core_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [13:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic        irq_pin,
	input wire logic        cpu_clk_en,
	input wire logic        halted,
	input wire logic        low_power,
	input wire logic        illegal_opcode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_rst_pc; $rose(rstn) |-> mem_addr == 14'h3FFD && mem_rd; endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("reset fetch address wrong");
	property p_gate; low_power |-> !cpu_clk_en && !illegal_opcode; endproperty
	a_gate: assert property (p_gate) else $error("core active while asleep");
	// no wake without a cause; sync depth gives four quiet cycles
	property p_stay; (low_power && !irq_pin)[*4] |=> low_power; endproperty
	a_stay: assert property (p_stay) else $error("woke without interrupt");
	property p_wake; (low_power && irq_pin)[*4] |-> ##[0:6] !low_power; endproperty
	a_wake: assert property (p_wake) else $error("interrupt did not wake");
	// halt holds until a control write
	property p_halt; halted && !avs_write |=> halted; endproperty
	a_halt: assert property (p_halt) else $error("left halt without command");
	property p_ans; $rose(avs_read) && avs_address != 8'h38 |=> !avs_waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("register read answer late");
	// illegal flag is a single pulse
	property p_ill; illegal_opcode |=> !illegal_opcode; endproperty
	a_ill: assert property (p_ill) else $error("illegal pulse too long");
	property p_win; mem_wr |-> mem_addr[13:8] == 6'h00; endproperty
	a_win: assert property (p_win) else $error("window write off direct page");
endmodule : core_monitor
bind tiny_core core_monitor mon (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
	.mem_addr, .mem_rd, .mem_wr, .irq_pin, .cpu_clk_en, .halted, .low_power, .illegal_opcode);

// ==== dv/prog_mem.sv ====
// Program and data memory model facing the core's byte port.
// Asynchronous read, write on the clock edge while mem_wr is high.
`timescale 1ns/100ps
module prog_mem (
	input  wire logic        clk,
	input  wire logic [13:0] mem_addr,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [16384];
	// taken carry-clear branch skips an AND that would clear the sum
	logic [7:0] prog [21] = '{8'hBC, 8'h01, 8'h00, 8'hAB, 8'h05, 8'hA9, 8'hFF, 8'hA4, 8'h00,
		8'hA9, 8'h00, 8'h6F, 8'h6E, 8'h48, 8'h34, 8'h02, 8'hA4, 8'h00, 8'h8F, 8'hAF, 8'hBF};
	// Filler is a shift, so a stray fetch never halts by luck
	initial begin
		foreach (mem[i]) mem[i] = 8'h48;
		// jump operand as 00 plus high bits, then low byte
		for (int i = 0; i < 3; i++) mem[14'h3FFD + i] = prog[i];
		for (int i = 3; i < 21; i++) mem[14'h0100 + i - 3] = prog[i];
		mem[14'h0020] = 8'h3A;
	end
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule : prog_mem

// ==== dv/tb.sv ====
// Self-checking bench: runs a short program, sleeps, wakes, halts, probes registers.
// Assumes prog_mem holds the program; registers reached over Avalon-MM.
`timescale 1ns/100ps
module tb;
	logic clk, rstn, avs_read, avs_write, avs_waitrequest, mem_rd, mem_wr, irq_pin;
	logic cpu_clk_en, halted, low_power, illegal_opcode;
	logic [7:0]  avs_address, mem_wdata, mem_rdata;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [13:0] mem_addr;
	int n_mismatch, total_checks, n;
	tiny_core uut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mem_addr, .mem_rd, .mem_wr,
		.mem_wdata, .mem_rdata, .irq_pin, .cpu_clk_en, .halted, .low_power, .illegal_opcode);
	prog_mem pm (.clk, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata);
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Request held until the edge at which waitrequest is low
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task results();
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end
	initial begin
		{rstn, avs_read, avs_write, irq_pin, avs_address, avs_writedata} = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		bus(1, 8'h3C, 8'h20);
		for (n = 0; n < 200 && low_power !== 1'b1; n++) @(negedge clk);
		check("low_power", low_power, 1);
		check("cpu_clk_en", cpu_clk_en, 0);
		repeat (10) @(negedge clk);
		check("still asleep", low_power, 1);
		@(posedge clk) irq_pin <= 1'b1;
		repeat (4) @(posedge clk);
		irq_pin <= 1'b0;
		for (n = 0; n < 200 && halted !== 1'b1; n++) @(negedge clk);
		check("halted", halted, 1);
		bus(0, 8'h0C, 8'h00);
		check("acc", q, 32'hB6);
		bus(0, 8'h04, 8'h00);
		check("status", q & 32'h33, 32'h03);
		bus(0, 8'h08, 8'h00);
		check("pc", q, 32'h01110112);
		bus(0, 8'h3C, 8'h00);
		check("pointer", q, 32'h20);
		bus(0, 8'h38, 8'h00);
		check("window read", q, 32'h3A);
		bus(1, 8'h38, 8'h77);
		bus(0, 8'h38, 8'h00);
		check("window write", q, 32'h77);
		check("mem 0020", pm.mem[14'h0020], 8'h77);
		bus(0, 8'h80, 8'h00);
		check("unmapped", q, 32'h0);
		bus(1, 8'h00, 8'h02);
		@(negedge clk);
		check("resumed", halted, 0);
		bus(1, 8'h00, 8'h01);
		for (n = 0; n < 20 && halted !== 1'b1; n++) @(negedge clk);
		check("halt request", halted, 1);
		results();
	end
endmodule : tb
